// ### core/pipc_top.sv
// Interrupt, collision, shared pin and loopback control of the PHY
//
// Behaviour
// - Depth code two gives six nibbles of loopback buffer, three gives eight.
// - Depth code zero gives four nibbles, one gives five; five after reset.
// - Loopback buffer absorbs receive versus transmit rate during far loopback.
// - Collision out only in half duplex unless full-duplex collision bit set.
// - Polarity one idles pin high, low on interrupt; zero is inverse.
// - Test bit forces interrupt continuously until software clears it.
// - Global enable gates event interrupts; each event needs own enable too.
// - Output enable zero makes pin power-down input; one drives interrupt.
// - Event status and enable register at index 0x12, resets to zero.
// - Event flags latch on event, clear on read, enable picks contribution.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "pipc_params.svh"

module pipc_top #(
   parameter int LB_DEPTH = 8
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Event pulses, bit 7 link quality down to bit 0 receive error
   input  wire logic [7:0]  eventPulse,
   // Collision
   input  wire logic        colRaw,
   input  wire logic        fullDuplex,
   output logic             colOut,
   // Far-end loopback
   input  wire logic        farLoopEn,
   input  wire logic [3:0]  rxNibble,
   input  wire logic        rxNibbleValid,
   input  wire logic        txNibbleReady,
   output logic [3:0]       txNibble,
   output logic             txNibbleValid,
   // Shared interrupt or power-down pin
   input  wire logic        irqPinIn,
   output logic             irqPinOut,
   output logic             irqPinOe,
   output logic             powerDownReq,
   // System interrupt
   output logic             sysIrq
);

   pipc_pkg::pipc_state_s cur_ff;
   pipc_pkg::pipc_state_s nxt_st;

   logic       addrPhase;
   logic       intCond;
   logic [3:0] fillLevel;
   logic       lbRdValid;
   logic [3:0] lbRdData;
   logic       lbOverflow;
   logic       lbUnderflow;
   logic       lbPop;
   logic [2:0] irqEvents;

   // ---------------------------------------------------------------
   // Loopback depth decode
   // ---------------------------------------------------------------
   always_comb begin
      case (cur_ff.ctrl[`PIPC_DEPTH_LSB +: 2])
         `PIPC_DCODE_4: fillLevel = `PIPC_FILL_4;
         `PIPC_DCODE_5: fillLevel = `PIPC_FILL_5;
         `PIPC_DCODE_6: fillLevel = `PIPC_FILL_6;
         `PIPC_DCODE_8: fillLevel = `PIPC_FILL_8;
         default:       fillLevel = `PIPC_FILL_5;
      endcase
   end

   // ---------------------------------------------------------------
   // Loopback buffer
   // ---------------------------------------------------------------
   assign lbPop = txNibbleReady & lbRdValid;

   pipc_lb_fifo #(
      .WIDTH (4),
      .DEPTH (LB_DEPTH)
   ) u_lb_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .enable    (farLoopEn),
      .fillLevel (fillLevel),
      .wrValid   (rxNibbleValid),
      .wrData    (rxNibble),
      .wrReady   (),
      .rdReady   (txNibbleReady),
      .rdValid   (lbRdValid),
      .rdData    (lbRdData),
      .overflow  (lbOverflow),
      .underflow (lbUnderflow)
   );

   // ---------------------------------------------------------------
   // Interrupt condition
   // ---------------------------------------------------------------
   assign intCond = cur_ff.ctrl[`PIPC_TEST_BIT]
                  | (cur_ff.ctrl[`PIPC_GIE_BIT]
                     & |(cur_ff.evtStat & cur_ff.evtEn));

   assign irqEvents[`PIPC_IRQ_COND_BIT] = intCond & ~cur_ff.condPrev;
   assign irqEvents[`PIPC_IRQ_OVF_BIT]  = lbOverflow;
   assign irqEvents[`PIPC_IRQ_UNF_BIT]  = lbUnderflow;

   assign addrPhase = hsel & hready & htrans[1];

   // ---------------------------------------------------------------
   // Register read multiplexer
   // ---------------------------------------------------------------
   function automatic logic [31:0] readMux(
      input pipc_pkg::pipc_state_s st
   );
      logic [31:0] val;
      val = 32'h0000_0000;
      case (st.dIdx)
         `PIPC_IDX_CTRL:
            val = {16'h0000, st.ctrl & `PIPC_CTRL_WMASK};
         `PIPC_IDX_EVT:
            val = {16'h0000, st.evtStat, st.evtEn};
         `PIPC_IDX_IRQSTAT:
            val = {29'h0000_0000, st.irqStat};
         `PIPC_IDX_IRQMASK:
            val = {29'h0000_0000, st.irqMask};
         default:
            val = 32'h0000_0000;
      endcase
      return val;
   endfunction

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic evtClear;
      logic [2:0] w1c;
      evtClear = 1'b0;
      w1c      = 3'h0;
      nxt_st   = cur_ff;

      // Write data phase; no wait state, applied at its closing edge
      if (cur_ff.wrPend) begin
         case (cur_ff.dIdx)
            `PIPC_IDX_CTRL:
               nxt_st.ctrl = hwdata[15:0] & `PIPC_CTRL_WMASK;
            `PIPC_IDX_EVT:
               nxt_st.evtEn = hwdata[7:0];
            `PIPC_IDX_IRQSTAT:
               w1c = hwdata[2:0];
            `PIPC_IDX_IRQMASK:
               nxt_st.irqMask = hwdata[2:0];
            default: ;
         endcase
      end
      nxt_st.wrPend = 1'b0;

      // Reads take one wait state so a read just after a write sees it
      case (cur_ff.bus)
         pipc_pkg::BUS_IDLE: begin
            nxt_st.hreadyout = 1'b1;
            if (addrPhase) begin
               nxt_st.dIdx = haddr[11:2];
               if (hwrite) begin
                  nxt_st.wrPend = 1'b1;
               end else begin
                  nxt_st.bus       = pipc_pkg::BUS_READ;
                  nxt_st.hreadyout = 1'b0;
               end
            end
         end
         pipc_pkg::BUS_READ: begin
            nxt_st.hrdata    = readMux(cur_ff);
            nxt_st.hreadyout = 1'b1;
            nxt_st.bus       = pipc_pkg::BUS_IDLE;
            evtClear         = (cur_ff.dIdx == `PIPC_IDX_EVT);
         end
         default: begin
            nxt_st.bus       = pipc_pkg::BUS_IDLE;
            nxt_st.hreadyout = 1'b1;
         end
      endcase

      // Flags clear on read; an event in the same cycle still lands
      nxt_st.evtStat = (evtClear ? 8'h00 : cur_ff.evtStat)
                     | eventPulse;

      nxt_st.irqStat  = (cur_ff.irqStat & ~w1c) | irqEvents;
      nxt_st.sysIrq   = |(cur_ff.irqStat & cur_ff.irqMask);
      nxt_st.condPrev = intCond;

      // Collision masked in full duplex unless enabled there
      nxt_st.colOut = colRaw & (~fullDuplex
                      | cur_ff.ctrl[`PIPC_COLFD_BIT]);

      // Shared pin direction and level
      nxt_st.pinOe  = cur_ff.ctrl[`PIPC_OE_BIT];
      nxt_st.pinOut = cur_ff.ctrl[`PIPC_POL_BIT] ?
                      ~intCond : intCond;
      nxt_st.powerDown = ~cur_ff.ctrl[`PIPC_OE_BIT] & ~irqPinIn;

      nxt_st.txNibble      = lbPop ? lbRdData : cur_ff.txNibble;
      nxt_st.txNibbleValid = lbPop;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cur_ff               <= '0;
         cur_ff.ctrl          <= `PIPC_CTRL_RESET;
         cur_ff.evtStat       <= 8'(`PIPC_EVT_RESET >> `PIPC_EVT_STAT_LSB);
         cur_ff.evtEn         <= 8'h00;
         cur_ff.irqStat       <= `PIPC_IRQ_RESET;
         cur_ff.irqMask       <= `PIPC_IRQ_RESET;
         cur_ff.bus           <= pipc_pkg::BUS_IDLE;
         cur_ff.hreadyout     <= 1'b1;
         cur_ff.pinOut        <= 1'b1;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hreadyout     = cur_ff.hreadyout;
   assign hresp         = 1'b0;
   assign hrdata        = cur_ff.hrdata;
   assign colOut        = cur_ff.colOut;
   assign txNibble      = cur_ff.txNibble;
   assign txNibbleValid = cur_ff.txNibbleValid;
   assign irqPinOut     = cur_ff.pinOut;
   assign irqPinOe      = cur_ff.pinOe;
   assign powerDownReq  = cur_ff.powerDown;
   assign sysIrq        = cur_ff.sysIrq;

endmodule

// ### inc/pipc_params.svh
// Register indices, field positions, reset values and depth codes
`ifndef PIPC_PARAMS_SVH
`define PIPC_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define PIPC_IDX_CTRL      10'h011
`define PIPC_IDX_EVT       10'h012
`define PIPC_IDX_IRQSTAT   10'h014
`define PIPC_IDX_IRQMASK   10'h015

// ---------------------------------------------------------------
// Control register fields and reset
// ---------------------------------------------------------------
`define PIPC_CTRL_RESET    16'h0108
`define PIPC_CTRL_WMASK    16'hFB1F
`define PIPC_DEPTH_LSB     8
`define PIPC_COLFD_BIT     4
`define PIPC_POL_BIT       3
`define PIPC_TEST_BIT      2
`define PIPC_GIE_BIT       1
`define PIPC_OE_BIT        0

// ---------------------------------------------------------------
// Event register fields and reset
// ---------------------------------------------------------------
`define PIPC_EVT_RESET     16'h0000
`define PIPC_EVT_STAT_LSB  8

// ---------------------------------------------------------------
// Loopback depth codes and fill levels in nibbles
// ---------------------------------------------------------------
`define PIPC_DCODE_4       2'h0
`define PIPC_DCODE_5       2'h1
`define PIPC_DCODE_6       2'h2
`define PIPC_DCODE_8       2'h3
`define PIPC_FILL_4        4'h4
`define PIPC_FILL_5        4'h5
`define PIPC_FILL_6        4'h6
`define PIPC_FILL_8        4'h8

// ---------------------------------------------------------------
// System interrupt status bits
// ---------------------------------------------------------------
`define PIPC_IRQ_COND_BIT  0
`define PIPC_IRQ_OVF_BIT   1
`define PIPC_IRQ_UNF_BIT   2
`define PIPC_IRQ_RESET     3'h0

`endif

// ### inc/pipc_pkg.sv
// Types shared by the interrupt and pin control block
package pipc_pkg;

   typedef enum logic {
      BUS_IDLE,
      BUS_READ
   } pipc_bus_e;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0]  evtStat;
      logic [7:0]  evtEn;
      logic [2:0]  irqStat;
      logic [2:0]  irqMask;
      pipc_bus_e   bus;
      logic        wrPend;
      logic [9:0]  dIdx;
      logic        hreadyout;
      logic [31:0] hrdata;
      logic        colOut;
      logic        pinOut;
      logic        pinOe;
      logic        powerDown;
      logic        sysIrq;
      logic        condPrev;
      logic [3:0]  txNibble;
      logic        txNibbleValid;
   } pipc_state_s;

endpackage

// ### core/pipc_lb_fifo.sv
// Far-end loopback elastic buffer between receive and transmit
`timescale 1ns/1ps

module pipc_lb_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   // Control
   input  wire logic             enable,
   input  wire logic [3:0]       fillLevel,
   // Receive side
   input  wire logic             wrValid,
   input  wire logic [WIDTH-1:0] wrData,
   output logic                  wrReady,
   // Transmit side
   input  wire logic             rdReady,
   output logic                  rdValid,
   output logic [WIDTH-1:0]      rdData,
   // Error pulses
   output logic                  overflow,
   output logic                  underflow
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [CW-1:0]               count;
      logic                        running;
   } pipc_fifo_s;

   pipc_fifo_s cur_ff;
   pipc_fifo_s nxt_st;
   logic       push;
   logic       pop;
   logic       full;
   logic       empty;

   assign full      = (cur_ff.count == CW'(DEPTH));
   assign empty     = (cur_ff.count == '0);
   assign wrReady   = enable & ~full;
   assign rdValid   = cur_ff.running & ~empty;
   assign rdData    = cur_ff.mem[cur_ff.rdPtr];
   assign push      = wrValid & wrReady;
   assign pop       = rdReady & rdValid;
   assign overflow  = enable & wrValid & full;
   assign underflow = enable & cur_ff.running & rdReady & empty;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = cur_ff;
      if (!enable) begin
         nxt_st.wrPtr   = '0;
         nxt_st.rdPtr   = '0;
         nxt_st.count   = '0;
         nxt_st.running = 1'b0;
      end else begin
         if (push) begin
            nxt_st.mem[cur_ff.wrPtr] = wrData;
            nxt_st.wrPtr = (cur_ff.wrPtr == AW'(DEPTH - 1)) ?
                           '0 : cur_ff.wrPtr + AW'(1);
         end
         if (pop) begin
            nxt_st.rdPtr = (cur_ff.rdPtr == AW'(DEPTH - 1)) ?
                           '0 : cur_ff.rdPtr + AW'(1);
         end
         nxt_st.count = cur_ff.count + CW'(push) - CW'(pop);
         // Draining waits for the programmed fill so that a faster
         // transmit clock never starves the frame mid-way
         if (!cur_ff.running && (CW'(cur_ff.count) >= CW'(fillLevel)))
            nxt_st.running = 1'b1;
         else if (cur_ff.running && empty && !push)
            nxt_st.running = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_st;
      end
   end

endmodule

// ### tb/pipc_monitor.sv
// Port-level assertions for the interrupt and pin control block
`timescale 1ns/1ps

module pipc_monitor #(
   parameter int LB_DEPTH = 8
) (
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       reset_n,
   // Register bus
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   // Collision
   input wire logic       colRaw,
   input wire logic       fullDuplex,
   input wire logic       colOut,
   // Loopback
   input wire logic       farLoopEn,
   input wire logic       txNibbleReady,
   input wire logic       txNibbleValid,
   // Shared pin
   input wire logic       irqPinIn,
   input wire logic       irqPinOe,
   input wire logic       powerDownReq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // ----------------------------
   // Bus timing
   // ----------------------------
   sequence s_rdReq;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence s_rdAns;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rdWait;
      s_rdReq |=> s_rdAns;
   endproperty
   a_rdWait: assert property (p_rdWait)
      else $error("read wait state wrong");
   property p_wrNoWait;
      hsel && hready && htrans[1] && hwrite |=> hreadyout;
   endproperty
   a_wrNoWait: assert property (p_wrNoWait)
      else $error("write stalled");

   // ----------------------------
   // Pins
   // ----------------------------
   property p_colHalf;
      colRaw && !fullDuplex |=> colOut;
   endproperty
   a_colHalf: assert property (p_colHalf)
      else $error("half duplex collision lost");
   property p_colNone;
      !colRaw |=> !colOut;
   endproperty
   a_colNone: assert property (p_colNone)
      else $error("collision without cause");
   property p_oeNoPd;
      irqPinOe |-> !powerDownReq;
   endproperty
   a_oeNoPd: assert property (p_oeNoPd)
      else $error("power-down while pin driven");
   property p_pdIn;
      !irqPinIn ##1 !irqPinOe |-> powerDownReq;
   endproperty
   a_pdIn: assert property (p_pdIn)
      else $error("power-down input ignored");
   property p_txReady;
      txNibbleValid |-> $past(txNibbleReady);
   endproperty
   a_txReady: assert property (p_txReady)
      else $error("nibble sent without ready");
   property p_txFlush;
      !farLoopEn [*2] |=> !txNibbleValid;
   endproperty
   a_txFlush: assert property (p_txFlush)
      else $error("nibble sent with loopback off");
endmodule

bind pipc_top pipc_monitor #(.LB_DEPTH(LB_DEPTH)) i_pipc_monitor (
   .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .colRaw(colRaw), .fullDuplex(fullDuplex), .colOut(colOut),
   .farLoopEn(farLoopEn), .txNibbleReady(txNibbleReady),
   .txNibbleValid(txNibbleValid), .irqPinIn(irqPinIn),
   .irqPinOe(irqPinOe), .powerDownReq(powerDownReq)
);

// ### tb/pipc_host_model.sv
// Host side: resolves the shared pin and sinks loopback nibbles
`timescale 1ns/1ps

module pipc_host_model (
   // Clock
   input  wire logic ref_clk,
   // Pin from the block
   input  wire logic irqPinOut,
   input  wire logic irqPinOe,
   // Host controls
   input  wire logic pdDrive,
   input  wire logic stall,
   // Loopback sink
   input  wire logic txNibbleValid,
   output logic      txNibbleReady,
   // Resolved pin and count
   output logic      pinLevel,
   output int        rxCount
);
   // Host drives its power-down level only while the block lets go
   assign pinLevel      = irqPinOe ? irqPinOut : pdDrive;
   assign txNibbleReady = !stall;
   initial rxCount = 0;
   always @(posedge ref_clk)
      if (txNibbleValid === 1'h1)
         rxCount <= rxCount + 1;
endmodule

// ### tb/pipc_bench.sv
// Self-checking bench for the interrupt and pin control block
`timescale 1ns/1ps
`include "pipc_params.svh"

module pipc_bench;
   logic        ref_clk, reset_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic        colRaw = 1'h0, fullDuplex = 1'h0, farLoopEn = 1'h0;
   logic        rxNibbleValid = 1'h0, pdDrive = 1'h0, stall = 1'h0;
   logic        hreadyout, hresp, colOut, txNibbleReady, txNibbleValid;
   logic        irqPinIn, irqPinOut, irqPinOe, powerDownReq, sysIrq;
   logic [1:0]  htrans = 2'h0;
   logic [3:0]  rxNibble = 4'h0, txNibble;
   logic [7:0]  eventPulse = 8'h00, ev, en;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, cv;
   logic [15:0] seed;
   int          num_errors = 0, total_checks = 0, rxCount, base, n;
   logic [3:0]  lbQ[$];

   pipc_top #(.LB_DEPTH(8)) i_pipc_top (
      .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .eventPulse(eventPulse), .colRaw(colRaw),
      .fullDuplex(fullDuplex), .colOut(colOut), .farLoopEn(farLoopEn),
      .rxNibble(rxNibble), .rxNibbleValid(rxNibbleValid),
      .txNibbleReady(txNibbleReady), .txNibble(txNibble),
      .txNibbleValid(txNibbleValid), .irqPinIn(irqPinIn),
      .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
      .powerDownReq(powerDownReq), .sysIrq(sysIrq));

   pipc_host_model i_pipc_host_model (
      .ref_clk(ref_clk), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
      .pdDrive(pdDrive), .stall(stall), .txNibbleValid(txNibbleValid),
      .txNibbleReady(txNibbleReady), .pinLevel(irqPinIn),
      .rxCount(rxCount));

   // ----------------------------
   // Helpers
   // ----------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic int fillOf(input logic [1:0] c);
      return (c == 2'h3) ? 8 : 4 + c;
   endfunction

   function automatic logic colExp(input logic cr, fd, cf);
      return cr & (!fd | cf);
   endfunction

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   // Single transfer; the bus sets the pace, not a fixed count
   task automatic bus(input logic wr, input logic [9:0] idx,
                      input logic [31:0] wd);
      hsel   <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {20'h0, idx, 2'h0};
      @(posedge ref_clk);
      while (hreadyout !== 1'h1) @(posedge ref_clk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge ref_clk);
      while (hreadyout !== 1'h1) @(posedge ref_clk);
      rd = hrdata;
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
      bus(1'h0, idx, 32'h0);
      chk(rd, exp);
      chk(hresp, 1'h0);
   endtask

   task automatic push(input int k);
      repeat (k) begin
         seed = lfsr(seed);
         rxNibble <= seed[3:0];
         lbQ.push_back(seed[3:0]);
         rxNibbleValid <= 1'h1;
         @(posedge ref_clk);
      end
      rxNibbleValid <= 1'h0;
   endtask

   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Loopback nibbles must leave in the order they went in
   always @(posedge ref_clk) begin
      if (txNibbleValid === 1'h1) begin
         if (lbQ.size() == 0)
            chk(32'h1, 32'h0);
         else
            chk(txNibble, lbQ.pop_front());
      end
   end

   initial begin
      tick(20000);
      num_errors++;
      stop_test;
   end

   // ----------------------------
   // Main sequence
   // ----------------------------
   initial begin
      seed = 16'h7126;
      tick(8);
      reset_n <= 1'h1;
      tick(1);
      rdc(`PIPC_IDX_CTRL, 32'h0108);
      rdc(`PIPC_IDX_EVT, 32'h0);
      rdc(`PIPC_IDX_IRQMASK, 32'h0);
      rdc(10'h3FF, 32'h0);
      chk(powerDownReq, 1'h1);
      pdDrive <= 1'h1;
      tick(2);
      chk(powerDownReq, 1'h0);
      pdDrive <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         cv = 32'h0101;
         cv[3] = !i[1];
         cv[2] = i[1] ^ i[0];
         bus(1'h1, `PIPC_IDX_CTRL, cv);
         tick(2);
         chk({irqPinOe, powerDownReq, irqPinIn}, {2'h2, cv[3] ^ cv[2]});
      end
      rdc(`PIPC_IDX_IRQSTAT, 32'h1);
      chk(sysIrq, 1'h0);
      bus(1'h1, `PIPC_IDX_IRQMASK, 32'h1);
      tick(2);
      chk(sysIrq, 1'h1);
      bus(1'h1, `PIPC_IDX_IRQSTAT, 32'h1);
      tick(2);
      chk(sysIrq, 1'h0);
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         {en, ev} = seed;
         seed = lfsr(seed);
         cv = 32'h0101;
         cv[1] = seed[0];
         cv[4] = seed[1];
         bus(1'h1, `PIPC_IDX_CTRL, cv);
         bus(1'h1, `PIPC_IDX_EVT, {24'h0, en});
         colRaw <= seed[2];
         fullDuplex <= seed[3];
         eventPulse <= ev;
         tick(1);
         eventPulse <= 8'h00;
         tick(3);
         chk(colOut, colExp(seed[2], seed[3], seed[1]));
         chk(irqPinIn, seed[0] & |(ev & en));
         rdc(`PIPC_IDX_EVT, {16'h0, ev, en});
         tick(2);
         chk(irqPinIn, 1'h0);
         rdc(`PIPC_IDX_EVT, {24'h0, en});
      end
      for (int c = 0; c < 4; c++) begin
         bus(1'h1, `PIPC_IDX_CTRL, 32'h0001 | (c << 8));
         n = fillOf(c[1:0]);
         base = rxCount;
         farLoopEn <= 1'h1;
         stall <= 1'h1;
         push(n - 1);
         stall <= 1'h0;
         tick(4);
         chk(rxCount - base, 0);
         stall <= 1'h1;
         push(1);
         tick(3);
         stall <= 1'h0;
         tick(16);
         chk(rxCount - base, n);
         farLoopEn <= 1'h0;
         tick(3);
      end
      // Second reset after control was rewritten
      reset_n <= 1'h0;
      tick(2);
      reset_n <= 1'h1;
      tick(1);
      rdc(`PIPC_IDX_CTRL, 32'h0108);
      rdc(`PIPC_IDX_EVT, 32'h0);
      stop_test;
   end
endmodule
